//--- core/ldcs_pkg.sv
package ldcs_pkg;

	// ************************************************************
	// Register map and fields
	// ************************************************************
	localparam logic [7:0] ADDR_MODE = 8'h00; // Drive configuration
	localparam logic [7:0] ADDR_BLINK = 8'h04; // Blink control
	localparam logic [7:0] ADDR_BANK = 8'h08; // Bank selectors
	localparam logic [7:0] ADDR_PTR = 8'h0C; // Data pointer and subaddress
	localparam logic [7:0] ADDR_DATA = 8'h10; // Display data nibble
	localparam logic [7:0] ADDR_STATUS = 8'h14; // Read-only state
	localparam int MODE_F_BIAS = 2; // Half bias select
	localparam int MODE_F_EN = 3; // Display enable
	localparam int MODE_F_SAVE = 4; // Power-saving frame divider
	localparam int BANK_F_IN = 0; // Write-side bank
	localparam int BANK_F_OUT = 1; // Display-side bank
	localparam int PTR_F_SUB = 5; // Subaddress field base

	// ************************************************************
	// Modes, levels and reset values
	// ************************************************************
	// Drive mode; code plus one is the active backplane count
	typedef enum logic [1:0] {
		MODE_STATIC = 2'b00,
		MODE_MUX2 = 2'b01,
		MODE_MUX3 = 2'b10,
		MODE_MUX4 = 2'b11
	} ldcs_mode_e;
	// Display state: parked at supply, or driving waveforms
	typedef enum logic {
		RUN_PARK = 1'b0,
		RUN_DRIVE = 1'b1
	} ldcs_run_e;
	localparam logic [1:0] LVL_VDD = 2'h0; // Positive supply
	localparam logic [1:0] LVL_MID1 = 2'h1; // Near tap, or midpoint at half bias
	localparam logic [1:0] LVL_MID2 = 2'h2; // Far tap, unused at half bias
	localparam logic [1:0] LVL_VLCD = 2'h3; // LCD supply
	localparam ldcs_mode_e RST_MODE = MODE_MUX4;
	localparam logic RST_BIAS_HALF = 1'b0;
	localparam logic RST_BLINK = 1'b0;
	localparam logic RST_BANK = 1'b0;
	localparam logic [4:0] RST_PTR = 5'h00;
	localparam logic [2:0] RST_SUB = 3'h0;
	localparam logic [4:0] RAM_LAST = 5'h17; // Address 23

	// ************************************************************
	// Timing
	// ************************************************************
	localparam logic [11:0] FRAME_DIV_NORMAL = 12'hB40; // 2880 clocks per frame
	localparam logic [11:0] FRAME_DIV_SAVE = 12'h1E0; // 480 clocks per frame

endpackage : ldcs_pkg

//--- core/ldcs_sync.sv
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// Two-stage synchroniser for pin inputs
// ************************************************************
module ldcs_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_in,
	// Data
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	import ldcs_pkg::*;

	// Stage one is read by stage two only
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} ldcs_sync_s;
	ldcs_sync_s st_q, st_d;

	// Shift the pin value along
	always_comb
	begin
		st_d = st_q;
		st_d.s1 = async_in;
		st_d.s2 = st_q.s1;
	end

	// State register
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			st_q <= '0;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	assign sync_out = st_q.s2;
endmodule : ldcs_sync
`default_nettype wire

//--- core/ldcs_level_map.sv
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// Drive level selection per backplane and segment line
// ************************************************************
module ldcs_level_map #(
	parameter int NSEG = 24
) (
	// Configuration and multiplex position
	input wire ldcs_pkg::ldcs_mode_e mode_in,
	input wire logic bias_half_in,
	input wire logic pol_in,
	input wire logic [1:0] row_in,
	// Segment data for this row
	input wire logic [NSEG-1:0] seg_on_in,
	// Level codes, two bits per line
	output logic [7:0] bp_lvl_out,
	output logic [2*NSEG-1:0] seg_lvl_out
);
	import ldcs_pkg::*;

	// Inverted phase mirrors the ladder so the LCD sees no DC
	// At half bias both taps are one node, so the midpoint stays on the near tap code
	function automatic logic [1:0] mirror(input logic pol, input logic half, input logic [1:0] c);
		logic [1:0] m;
		m = pol ? c : ~c;
		return (half && m == LVL_MID2) ? LVL_MID1 : m;
	endfunction : mirror

	// Row served by a backplane; paired lines carry the same row
	function automatic logic [1:0] bp_row(input ldcs_mode_e m, input logic [1:0] i);
		case (m)
			MODE_STATIC: return 2'h0;
			MODE_MUX2: return {1'b0, i[0]};
			MODE_MUX3: return (i == 2'h3) ? 2'h1 : i;
			default: return i;
		endcase
	endfunction : bp_row

	genvar g;
	// Backplanes: selected at extreme, others on inner tap
	generate
		for (g = 0; g < 4; g++)
		begin : g_bp
			logic sel;
			assign sel = (bp_row(mode_in, 2'(g)) == row_in);
			assign bp_lvl_out[2*g+:2] = mirror(pol_in, bias_half_in, sel ? LVL_VDD :
				(bias_half_in ? LVL_MID1 : LVL_MID2));
		end
	endgenerate

	// Segments: on at opposite extreme, off near backplane
	generate
		for (g = 0; g < NSEG; g++)
		begin : g_seg
			assign seg_lvl_out[2*g+:2] = mirror(pol_in, bias_half_in, seg_on_in[g] ? LVL_VLCD :
				((mode_in == MODE_STATIC) ? LVL_VDD : LVL_MID1));
		end
	endgenerate
endmodule : ldcs_level_map
`default_nettype wire

//--- core/ldcs_core.sv
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// Display driver configuration and timing core
// ************************************************************
module ldcs_core #(
	parameter int NSEG = 24, // Segment lines
	parameter logic [7:0] OSC_HALF = 8'h36, // Internal clock half period, sys cycles
	parameter logic [5:0] BLINK_FRAMES = 6'h20 // Frames per blink phase
) (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_in,
	// Register port
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out,
	// Straps and clock pin
	input wire logic clock_source_select_in,
	input wire logic [2:0] hw_subaddr_in,
	input wire logic clk_pin_in,
	output logic clk_pin_out,
	output logic clk_pin_oe_out,
	// Display drive level codes
	output logic [7:0] backplane_out,
	output logic [2*NSEG-1:0] segment_out
);
	import ldcs_pkg::*;

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		ldcs_run_e run; // Parked until enabled
		ldcs_mode_e mode; // Drive mode
		logic bias_half; // Half bias when set
		logic psave; // Power-saving divider
		logic blink_en; // Blinking enabled
		logic bank_in; // Write-side bank
		logic bank_out; // Display-side bank
		logic [4:0] ptr; // Display data pointer
		logic [2:0] sub; // Subaddress counter
		logic [NSEG-1:0][3:0] ram; // Display memory
		logic ext; // External clock in use
		logic [7:0] osc_cnt; // Internal oscillator divider
		logic clk_o; // Internal clock level
		logic clk_oe; // Clock pin driven
		logic clk_prev; // Last synced pin level
		logic [11:0] tick_cnt; // Ticks within slot
		logic [2:0] slot; // {row, polarity}
		logic frame; // Frame end pulse
		logic [5:0] blink_cnt; // Frames in blink phase
		logic blank; // Segments blanked
		logic [7:0] bp; // Backplane levels
		logic [2*NSEG-1:0] seg; // Segment levels
		logic [31:0] rdata; // Read answer
	} ldcs_core_s;
	ldcs_core_s st_q, st_d;

	logic [4:0] pins_sync; // Synced straps and clock pin
	logic sel_ext; // Clock source strap
	logic clk_pin_s; // Synced clock pin
	logic [2:0] hw_sub; // Synced subaddress strap
	logic tick; // One device clock period
	logic [11:0] slot_len; // Ticks per slot
	logic [1:0] row; // Multiplex row
	logic pol; // Waveform phase
	logic bank_act; // Alternate bank shown
	logic [NSEG-1:0] seg_on; // Segment data for row
	logic [7:0] bp_lvl; // Mapped backplane levels
	logic [2*NSEG-1:0] seg_lvl; // Mapped segment levels

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	ldcs_sync #(.W(5)) u_sync (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.async_in({clock_source_select_in, clk_pin_in, hw_subaddr_in}),
		.sync_out(pins_sync)
	);
	assign sel_ext = pins_sync[4];
	assign clk_pin_s = pins_sync[3];
	assign hw_sub = pins_sync[2:0];

	// ************************************************************
	// Timing chain
	// ************************************************************
	// Tick from internal divider or external pin rising edge
	assign tick = st_q.ext ? (clk_pin_s & ~st_q.clk_prev) :
		((st_q.osc_cnt == OSC_HALF - 8'h01) & ~st_q.clk_o);

	// Slot is a frame share: frame = 2 phases per active row
	always_comb
	begin
		logic [11:0] div;
		div = st_q.psave ? FRAME_DIV_SAVE : FRAME_DIV_NORMAL;
		case (st_q.mode)
			MODE_STATIC: slot_len = div / 12'h002;
			MODE_MUX2: slot_len = div / 12'h004;
			MODE_MUX3: slot_len = div / 12'h006;
			default: slot_len = div / 12'h008;
		endcase
	end

	assign row = st_q.slot[2:1];
	assign pol = st_q.slot[0];
	// Bank switching only exists in static and two-row modes
	assign bank_act = st_q.bank_out & (st_q.mode <= MODE_MUX2);

	// Pick the memory bit of the current row per segment
	genvar g;
	generate
		for (g = 0; g < NSEG; g++)
		begin : g_data
			assign seg_on[g] = st_q.ram[g][{row[1] | bank_act, row[0]}] & ~st_q.blank;
		end
	endgenerate

	ldcs_level_map #(.NSEG(NSEG)) u_map (
		.mode_in(st_q.mode),
		.bias_half_in(st_q.bias_half),
		.pol_in(pol),
		.row_in(row),
		.seg_on_in(seg_on),
		.bp_lvl_out(bp_lvl),
		.seg_lvl_out(seg_lvl)
	);

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb
	begin
		st_d = st_q;
		st_d.frame = 1'b0;
		st_d.rdata = 32'h0000_0000;
		// Clock source follows the strap
		st_d.ext = sel_ext;
		st_d.clk_oe = ~st_q.ext;
		st_d.clk_prev = clk_pin_s;
		// Internal oscillator, also driven out for cascades
		if (st_q.osc_cnt == OSC_HALF - 8'h01)
		begin
			st_d.osc_cnt = 8'h00;
			st_d.clk_o = ~st_q.clk_o;
		end
		else
		begin
			st_d.osc_cnt = st_q.osc_cnt + 8'h01;
		end
		// Slot and frame sequencing
		if (tick)
		begin
			if (st_q.tick_cnt >= slot_len - 12'h001)
			begin
				st_d.tick_cnt = 12'h000;
				if (st_q.slot >= {st_q.mode, 1'b1})
				begin
					st_d.slot = 3'h0;
					st_d.frame = 1'b1;
				end
				else
				begin
					st_d.slot = st_q.slot + 3'h1;
				end
			end
			else
			begin
				st_d.tick_cnt = st_q.tick_cnt + 12'h001;
			end
		end
		// Blink phase counted in frames
		if (!st_q.blink_en)
		begin
			st_d.blank = 1'b0;
			st_d.blink_cnt = 6'h00;
		end
		else if (st_q.frame)
		begin
			if (st_q.blink_cnt == BLINK_FRAMES - 6'h01)
			begin
				st_d.blink_cnt = 6'h00;
				st_d.blank = ~st_q.blank;
			end
			else
			begin
				st_d.blink_cnt = st_q.blink_cnt + 6'h01;
			end
		end
		// Register writes
		if (wr_in)
		begin
			case (addr_in)
				ADDR_MODE:
				begin
					// Takes effect at once; slot and tick counters restart from zero
					st_d.mode = ldcs_mode_e'(wdata_in[1:0]);
					st_d.bias_half = wdata_in[MODE_F_BIAS];
					st_d.psave = wdata_in[MODE_F_SAVE];
					st_d.run = wdata_in[MODE_F_EN] ? RUN_DRIVE : RUN_PARK;
					st_d.slot = 3'h0;
					st_d.tick_cnt = 12'h000;
				end
				ADDR_BLINK: st_d.blink_en = wdata_in[0];
				ADDR_BANK:
				begin
					st_d.bank_in = wdata_in[BANK_F_IN];
					st_d.bank_out = wdata_in[BANK_F_OUT];
				end
				ADDR_PTR:
				begin
					// Out-of-range pointer values are ignored
					if (wdata_in[4:0] <= RAM_LAST)
					begin
						st_d.ptr = wdata_in[4:0];
					end
					st_d.sub = wdata_in[PTR_F_SUB+:3];
				end
				ADDR_DATA:
				begin
					// Store only when the counter matches the strap
					if (st_q.sub == hw_sub)
					begin
						if (st_q.bank_in && st_q.mode <= MODE_MUX2)
						begin
							st_d.ram[st_q.ptr][3:2] = wdata_in[1:0];
						end
						else
						begin
							st_d.ram[st_q.ptr] = wdata_in[3:0];
						end
					end
					// Pointer moves anyway; overflow walks to next device
					if (st_q.ptr == RAM_LAST)
					begin
						st_d.ptr = 5'h00;
						st_d.sub = st_q.sub + 3'h1;
					end
					else
					begin
						st_d.ptr = st_q.ptr + 5'h01;
					end
				end
				default:
				begin
				end
			endcase
		end
		// Register reads, answer stands one cycle
		if (rd_in)
		begin
			case (addr_in)
				ADDR_MODE: st_d.rdata = {27'h0, st_q.psave, st_q.run == RUN_DRIVE,
					st_q.bias_half, st_q.mode};
				ADDR_BLINK: st_d.rdata = {31'h0, st_q.blink_en};
				ADDR_BANK: st_d.rdata = {30'h0, st_q.bank_out, st_q.bank_in};
				ADDR_PTR: st_d.rdata = {24'h0, st_q.sub, st_q.ptr};
				ADDR_STATUS: st_d.rdata = {27'h0, st_q.slot, st_q.blank, st_q.ext};
				default: st_d.rdata = 32'h0000_0000;
			endcase
		end
		// Outputs parked at supply until configured
		if (st_q.run == RUN_DRIVE)
		begin
			st_d.bp = bp_lvl;
			st_d.seg = seg_lvl;
		end
		else
		begin
			st_d.bp = {4{LVL_VDD}};
			st_d.seg = {NSEG{LVL_VDD}};
		end
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			st_q <= '0;
			st_q.mode <= RST_MODE;
			st_q.bias_half <= RST_BIAS_HALF;
			st_q.blink_en <= RST_BLINK;
			st_q.bank_in <= RST_BANK;
			st_q.bank_out <= RST_BANK;
			st_q.ptr <= RST_PTR;
			st_q.sub <= RST_SUB;
			st_q.clk_oe <= 1'b1;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	assign rdata_out = st_q.rdata;
	assign clk_pin_out = st_q.clk_o;
	assign clk_pin_oe_out = st_q.clk_oe;
	assign backplane_out = st_q.bp;
	assign segment_out = st_q.seg;

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (rst_in);

	park_at_vdd_a: assert property (st_q.run == RUN_PARK |=> backplane_out == 8'h00) else $error("outputs left supply level");
	park_seg_a: assert property (st_q.run == RUN_PARK && !wr_in |=> segment_out == '0) else $error("segments left supply level");
	reset_mode_a: assert property ($past(rst_in) |-> st_q.mode == MODE_MUX4 && !st_q.bias_half) else $error("reset drive mode wrong");
	reset_blink_a: assert property ($past(rst_in) |-> !st_q.blink_en && !st_q.blank) else $error("blink active after reset");
	reset_bank_a: assert property ($past(rst_in) |-> !st_q.bank_in && !st_q.bank_out) else $error("bank not reset");
	reset_ptr_a: assert property ($past(rst_in) |-> st_q.ptr == 5'h00 && st_q.sub == 3'h0) else $error("pointer not cleared");
	int_clk_drive_a: assert property (!st_q.ext [*2] |-> clk_pin_oe_out) else $error("clock pin not driven");
	ext_clk_input_a: assert property (st_q.ext [*2] |-> !clk_pin_oe_out) else $error("clock pin driven in external mode");
	mode_load_a: assert property (wr_in && addr_in == ADDR_MODE |=> st_q.mode == $past(wdata_in[1:0]) && st_q.bias_half == $past(wdata_in[MODE_F_BIAS])) else $error("mode not loaded");
	half_levels_a: assert property (st_q.bias_half && st_q.mode != MODE_STATIC |-> bp_lvl[1:0] != LVL_MID2 && bp_lvl[7:6] != LVL_MID2) else $error("middle tap used at half bias");
	static_levels_a: assert property (st_q.mode == MODE_STATIC |-> bp_lvl == 8'h00 || bp_lvl == 8'hFF) else $error("static backplane level wrong");
	slot_range_a: assert property (st_q.slot <= {st_q.mode, 1'b1} || $past(wr_in)) else $error("row beyond active backplanes");
	slot_len_a: assert property (tick && st_q.tick_cnt == slot_len - 12'h001 && st_q.slot == {st_q.mode, 1'b1} |=> st_q.frame) else $error("frame end missed");

	frame_seen_c: cover property (st_q.frame && st_q.run == RUN_DRIVE);
	ext_clock_c: cover property (st_q.ext && tick);
	blink_c: cover property (st_q.blank && st_q.run == RUN_DRIVE);
	half_bias_c: cover property (st_q.bias_half && st_q.mode == MODE_MUX2 && st_q.frame);
endmodule : ldcs_core
`default_nettype wire

//--- tb/ldcs_ext_clock.sv
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// External clock source on the shared clock pin
// ************************************************************
module ldcs_ext_clock #(
	parameter int HALF_NS = 200 // Half period, 2.5 MHz line
) (
	// Clock line towards the core
	output logic clk_line_out
);
	// Free running from time zero; never gated, so outputs cannot freeze
	initial
	begin
		clk_line_out = 1'b0;
		#13; // Phase unrelated to the system clock
		forever
		begin
			#HALF_NS clk_line_out = ~clk_line_out;
		end
	end
endmodule : ldcs_ext_clock
`default_nettype wire

//--- tb/ldcs_core_bench.sv
`timescale 1ns/10ps
`default_nettype none
module ldcs_core_bench;
	import ldcs_pkg::*;
	// ************************************************************
	// Signals and tables
	// ************************************************************
	typedef struct {logic wr; logic [7:0] a; logic [31:0] d;} ldcs_row_s;
	typedef struct {logic [31:0] w; logic [3:0] seen; logic [3:0] sseen;} ldcs_mrow_s;
	localparam int HOST_WAIT = 20000; // 1 ms of 50 ns cycles before the first access
	logic clk_sys_in; // System clock
	logic rst_in; // Async reset
	logic [7:0] addr_in;
	logic [31:0] wdata_in;
	logic wr_in;
	logic rd_in;
	logic [31:0] rdata_out;
	logic clock_source_select_in; // Strap
	logic clk_pin_out;
	logic clk_pin_oe_out;
	logic [7:0] backplane_out;
	logic [47:0] segment_out;
	wire logic ext_pin; // Partner clock
	wire logic clk_pin_wire; // Resolved pin level
	logic [31:0] d;
	logic [3:0] seen;
	logic [3:0] sseen; // Segment 0 codes seen
	time t0; // Start of pin clock measurement
	int fails;
	int checked;
	int bad;
	int n;
	// Register rows: reads compare against d, writes load d
	ldcs_row_s rows[13] = '{
		'{1'b0, ADDR_MODE, 32'h3}, '{1'b0, ADDR_BLINK, 32'h0},
		'{1'b0, ADDR_BANK, 32'h0}, '{1'b0, ADDR_PTR, 32'h0},
		'{1'b1, ADDR_BLINK, 32'h1}, '{1'b0, ADDR_BLINK, 32'h1},
		'{1'b1, ADDR_BANK, 32'h3}, '{1'b0, ADDR_BANK, 32'h3},
		'{1'b1, ADDR_PTR, 32'h17}, '{1'b1, ADDR_DATA, 32'h5},
		'{1'b0, ADDR_PTR, 32'h20},
		'{1'b1, 8'h18, 32'hFF}, '{1'b0, 8'h18, 32'h0}};
	// Mode rows: enable and save set, with backplane and segment 0 codes seen
	ldcs_mrow_s mrows[6] = '{
		'{32'h18, 4'h9, 4'h9}, '{32'h1D, 4'hB, 4'h2}, '{32'h19, 4'hF, 4'h6},
		'{32'h1E, 4'hB, 4'h2}, '{32'h1B, 4'hF, 4'h6}, '{32'h1F, 4'hB, 4'h2}};
	assign clk_pin_wire = clk_pin_oe_out ? clk_pin_out : ext_pin;
	ldcs_ext_clock i_ext (.clk_line_out(ext_pin));
	ldcs_core #(.NSEG(24), .OSC_HALF(8'h02), .BLINK_FRAMES(6'h02)) i_dut (
		.clk_sys_in(clk_sys_in), .rst_in(rst_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.clock_source_select_in(clock_source_select_in), .hw_subaddr_in(3'h0),
		.clk_pin_in(clk_pin_wire), .clk_pin_out(clk_pin_out),
		.clk_pin_oe_out(clk_pin_oe_out), .backplane_out(backplane_out),
		.segment_out(segment_out));
	// ************************************************************
	// Compare, bus and observation tasks
	// ************************************************************
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
		checked++;
		if (got !== exp)
		begin
			fails++;
			$display("BAD %0t %s got %h want %h", $time, m, got, exp);
		end
	endtask : chk_word
	task automatic chk_len(input int got, input int exp, input int tol, input string m);
		checked++;
		if (got > exp + tol || got < exp - tol)
		begin
			fails++;
			$display("BAD %0t %s got %0d want %0d", $time, m, got, exp);
		end
	endtask : chk_len
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_sys_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= v;
		@(posedge clk_sys_in);
		wr_in <= 1'b0;
	endtask : wr_reg
	// Read data is taken in the one cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk_sys_in);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge clk_sys_in);
		rd_in <= 1'b0;
		#1 v = rdata_out;
	endtask : rd_reg
	// Collect backplane codes and count broken pairings for the mode
	task automatic watch(input int cyc, input logic [1:0] md, output logic [3:0] s,
		output logic [3:0] ss, output int nb);
		s = 4'h0;
		ss = 4'h0;
		nb = 0;
		repeat (cyc)
		begin
			@(posedge clk_sys_in);
			#1;
			for (int b = 0; b < 4; b++)
				s = s | (4'h1 << backplane_out[2*b+:2]);
			ss = ss | (4'h1 << segment_out[1:0]);
			if (md == MODE_STATIC && backplane_out !== {4{backplane_out[1:0]}})
				nb++;
			if (md == MODE_MUX2 && backplane_out[3:0] !== backplane_out[7:4])
				nb++;
			if (md == MODE_MUX3 && backplane_out[7:6] !== backplane_out[3:2])
				nb++;
		end
	endtask : watch
	// Cycles of one whole slot, between two backplane changes
	task automatic slot_len(output int len);
		logic [7:0] p;
		// Skip the edge of the mode write so the old levels are never timed
		@(posedge clk_sys_in) #1;
		p = backplane_out;
		for (int k = 0; k < 5000 && backplane_out === p; k++)
			@(posedge clk_sys_in) #1;
		p = backplane_out;
		len = 0;
		for (int k = 0; k < 5000 && backplane_out === p; k++)
		begin
			@(posedge clk_sys_in) #1;
			len++;
		end
	endtask : slot_len
	task automatic summarize();
		if (fails == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : summarize
	// ************************************************************
	// Clock, watchdog and sequence
	// ************************************************************
	initial
	begin
		clk_sys_in = 1'b0;
		forever
			#25 clk_sys_in = ~clk_sys_in;
	end
	// Whole run needs about 40000 cycles
	initial
	begin
		repeat (60000) @(posedge clk_sys_in);
		fails++;
		summarize();
	end
	initial
	begin
		rst_in = 1'b1;
		wr_in = 1'b0;
		rd_in = 1'b0;
		addr_in = 8'h00;
		wdata_in = 32'h0;
		clock_source_select_in = 1'b0;
		fails = 0;
		checked = 0;
		repeat (10) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		// Parked outputs and internal clock driven out
		// No register access until the host wait is over
		watch(HOST_WAIT, MODE_MUX4, seen, sseen, bad);
		chk_word({28'h0, seen}, 32'h1, "parked bp");
		chk_word({31'h0, segment_out !== 48'h0}, 32'h0, "parked seg");
		// Forty pin periods at four system cycles each
		@(posedge clk_pin_out);
		t0 = $time;
		repeat (40) @(posedge clk_pin_out);
		chk_len(int'($time - t0), 8000, 0, "pin clock");
		chk_word({31'h0, clk_pin_oe_out}, 32'h1, "pin drive");
		rd_reg(ADDR_STATUS, d);
		chk_word(d & 32'h1, 32'h0, "internal clock");
		for (int i = 0; i < 13; i++)
		begin
			if (rows[i].wr)
				wr_reg(rows[i].a, rows[i].d);
			else
			begin
				rd_reg(rows[i].a, d);
				chk_word(d, rows[i].d, "reg");
			end
		end
		for (int i = 0; i < 6; i++)
		begin
			wr_reg(ADDR_MODE, mrows[i].w);
			watch(2000, mrows[i].w[1:0], seen, sseen, bad);
			chk_word({28'h0, seen}, {28'h0, mrows[i].seen}, "levels");
			chk_word({28'h0, sseen}, {28'h0, mrows[i].sseen}, "seg levels");
			chk_len(bad, 0, 0, "pairing");
		end
		// Slot lengths: frame over eight slots at four cycles per tick
		wr_reg(ADDR_MODE, 32'h1B);
		slot_len(n);
		chk_len(n, 240, 0, "save slot");
		wr_reg(ADDR_MODE, 32'h0B);
		slot_len(n);
		chk_len(n, 1440, 0, "normal slot");
		// External clock on the pin, eight cycles per tick
		@(posedge clk_sys_in);
		clock_source_select_in <= 1'b1;
		repeat (8) @(posedge clk_sys_in);
		rd_reg(ADDR_STATUS, d);
		chk_word(d & 32'h1, 32'h1, "external clock");
		chk_word({31'h0, clk_pin_oe_out}, 32'h0, "pin released");
		wr_reg(ADDR_MODE, 32'h1B);
		slot_len(n);
		chk_len(n, 480, 2, "ext slot");
		// Second reset in mid-run
		@(posedge clk_sys_in);
		rst_in <= 1'b1;
		clock_source_select_in <= 1'b0;
		repeat (3) @(posedge clk_sys_in);
		#1;
		chk_word({24'h0, backplane_out}, 32'h0, "reset bp");
		chk_word({31'h0, segment_out !== 48'h0}, 32'h0, "reset seg");
		chk_word({31'h0, clk_pin_oe_out}, 32'h1, "reset pin drive");
		@(posedge clk_sys_in);
		rst_in <= 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			rd_reg(rows[i].a, d);
			chk_word(d, rows[i].d, "reset reg");
		end
		summarize();
	end
endmodule : ldcs_core_bench
`default_nettype wire
